// ### inc/rco_defines.svh
/*
 * constants for the reference clock output block: register offsets, field
 * positions, reset value and divider widths.
 * assumes: included by bare name from inc/, no other header needed.
 */
`ifndef RCO_DEFINES_SVH
`define RCO_DEFINES_SVH

// =====================================================================
// register map
// =====================================================================
`define RCO_CTRL_OFFSET    12'h000
`define RCO_STATUS_OFFSET  12'h004
`define RCO_CTRL_RESET     16'h0000

// =====================================================================
// control fields
// =====================================================================
`define RCO_BIT_OUT_EN     15
`define RCO_BIT_SLEEP_RUN  13
`define RCO_BIT_SRC_SEL    12
`define RCO_DIV_HI         11
`define RCO_DIV_LO         8
`define RCO_CTRL_WMASK     16'hbf00

// =====================================================================
// status fields
// =====================================================================
`define RCO_ST_RUNNING     0
`define RCO_ST_PIN         1
`define RCO_ST_SRC_ACTIVE  2

// =====================================================================
// divider
// =====================================================================
`define RCO_DIV_W          4
`define RCO_CNT_W          15

`endif

// ### inc/rco_pkg.sv
/*
 * types shared by the reference clock output block.
 * assumes: rco_defines.svh is on the include path.
 */
`include "rco_defines.svh"

package rco_pkg;

    // =================================================================
    // state of the divider
    // =================================================================
    typedef enum logic [1:0] {
        RCO_IDLE    = 2'b00,
        RCO_RUN     = 2'b01,
        RCO_PARKED  = 2'b10
    } rco_state_t;

    typedef struct packed {
        logic [`RCO_CNT_W-1:0] count;
        logic                  tick_out;
        logic                  pin_q;
        logic                  pin_oe;
        rco_state_t            state;
    } rco_div_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rco_regs_t;

endpackage

// ### rtl/rco_divider.sv
/*
 * power-of-two divider for the reference clock output.
 * base clock arrives as a one-cycle enable pulse on the pclk domain, so the
 * pin toggles on base edges and the output stays glitch free.
 * assumes: base_tick is already synchronous to pclk.
 */
`timescale 1ns/1ps

module rco_divider
    import rco_pkg::*;
#(
    parameter int DIV_W = `RCO_DIV_W,
    parameter int CNT_W = `RCO_CNT_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic             base_tick,
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  pin_out,
    output logic                  running
);

    rco_div_t r;
    rco_div_t next_r;

    // half period in base ticks is 2**(div-1); code 0 passes ticks through
    function automatic logic [CNT_W-1:0] half_period(input logic [DIV_W-1:0] d);
        half_period = (d == '0) ? CNT_W'(1) : (CNT_W'(1) << (d - DIV_W'(1)));
    endfunction

    // =================================================================
    // next state
    // =================================================================
    always_comb begin
        next_r = r;
        case (r.state)
            RCO_IDLE: begin
                next_r.pin_q = 1'b0;
                next_r.count = '0;
                if (run) begin
                    next_r.state = RCO_RUN;
                end
            end
            RCO_RUN: begin
                if (!run) begin
                    // park until the next base tick, so a stop ends a high phase on a base edge
                    next_r.state = RCO_PARKED;
                end else if (base_tick) begin
                    if (divisor == '0) begin
                        next_r.pin_q = 1'b1;
                    end else if (r.count + CNT_W'(1) >= half_period(divisor)) begin
                        next_r.count = '0;
                        next_r.pin_q = ~r.pin_q;
                    end else begin
                        next_r.count = r.count + CNT_W'(1);
                    end
                end else if (divisor == '0) begin
                    next_r.pin_q = 1'b0;                             // pass-through follows the base
                end
            end
            RCO_PARKED: begin
                if (!r.pin_q || base_tick) begin
                    next_r.pin_q = 1'b0;
                    next_r.count = '0;
                    next_r.state = RCO_IDLE;
                end
            end
            default: begin
                next_r.state = RCO_IDLE;
            end
        endcase
        next_r.tick_out = (r.state == RCO_RUN);
        next_r.pin_oe   = 1'b0;
    end

    // =================================================================
    // state register
    // =================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    assign pin_out = r.pin_q;
    assign running = r.tick_out;

endmodule // rco_divider

// ### rtl/rco_ref_clock_out.sv
/*
 * reference clock output block: apb control register, base clock choice,
 * sleep gating and the divided clock driven to the reference output pin.
 * assumes: osc_clk_in arrives asynchronously and is at most a quarter of
 * pclk; the system base clock is represented by pclk itself.
 */
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps

module rco_ref_clock_out
    import rco_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        osc_clk_in,
    input  wire logic        sleep_mode,
    output logic             ref_clock_out_pin,
    output logic             ref_clock_out_pin_oe
);

    // =================================================================
    // state
    // =================================================================
    typedef struct packed {
        logic [15:0] ctrl;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        osc_s1;
        logic        osc_s2;
        logic        osc_prev;
        logic        pin;
        logic        pin_oe;
    } rco_top_t;

    rco_top_t r;
    rco_top_t next_r;

    logic               div_pin;
    logic               div_running;
    logic               base_tick;
    logic               run;
    logic               sel_hit;
    logic [15:0]        wr_val;

    // one address decode shared by read and write paths
    function automatic logic is_ctrl(input logic [11:0] a);
        is_ctrl = (a == `RCO_CTRL_OFFSET);
    endfunction

    function automatic logic is_status(input logic [11:0] a);
        is_status = (a == `RCO_STATUS_OFFSET);
    endfunction

    // =================================================================
    // base clock choice and gating
    // =================================================================
    // oscillator rising edge seen after the two-stage synchroniser; system
    // clock ticks every pclk (pclk stands in for it), so the divider counts
    // one base edge per tick in both cases
    assign base_tick = r.ctrl[`RCO_BIT_SRC_SEL] ? (r.osc_s2 & ~r.osc_prev)
                                                : 1'b1;
    // the crystal must already run when selected; nothing here starts it
    assign run = r.ctrl[`RCO_BIT_OUT_EN] &
                 (~sleep_mode | r.ctrl[`RCO_BIT_SLEEP_RUN]);

    assign sel_hit = psel & penable;

    // byte lanes of the 16-bit control register
    always_comb begin
        wr_val = r.ctrl;
        if (pstrb[0]) begin
            wr_val[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
            wr_val[15:8] = pwdata[15:8];
        end
        wr_val = wr_val & `RCO_CTRL_WMASK;
    end

    // =================================================================
    // next state
    // =================================================================
    always_comb begin
        next_r          = r;
        next_r.osc_s1   = osc_clk_in;
        next_r.osc_s2   = r.osc_s1;
        next_r.osc_prev = r.osc_s2;
        next_r.pready   = 1'b0;
        next_r.pslverr  = 1'b0;
        // apb: one wait state, answer in the cycle after penable rises
        if (sel_hit && !r.pready) begin
            next_r.pready = 1'b1;
            if (pwrite) begin
                if (is_ctrl(paddr)) begin
                    next_r.ctrl = wr_val;
                end else if (!is_status(paddr)) begin
                    next_r.pslverr = 1'b1;
                end
            end else begin
                next_r.prdata = '0;
                if (is_ctrl(paddr)) begin
                    next_r.prdata[15:0] = r.ctrl;
                end else if (is_status(paddr)) begin
                    next_r.prdata[`RCO_ST_RUNNING]    = div_running;
                    next_r.prdata[`RCO_ST_PIN]        = r.pin;
                    next_r.prdata[`RCO_ST_SRC_ACTIVE] = r.ctrl[`RCO_BIT_SRC_SEL];
                end else begin
                    next_r.pslverr = 1'b1;
                end
            end
        end
        // pin follows divider; released when disabled
        next_r.pin    = div_pin & r.ctrl[`RCO_BIT_OUT_EN];
        next_r.pin_oe = r.ctrl[`RCO_BIT_OUT_EN];
    end

    // =================================================================
    // registers
    // =================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r      <= '0;
            r.ctrl <= `RCO_CTRL_RESET;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    // =================================================================
    // divider
    // =================================================================
    rco_divider #(
        .DIV_W (`RCO_DIV_W),
        .CNT_W (`RCO_CNT_W)
    ) u_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .base_tick (base_tick),
        .run       (run),
        .divisor   (r.ctrl[`RCO_DIV_HI:`RCO_DIV_LO]),
        .pin_out   (div_pin),
        .running   (div_running)
    );

    assign prdata               = r.prdata;
    assign pready               = r.pready;
    assign pslverr              = r.pslverr;
    assign ref_clock_out_pin    = r.pin;
    assign ref_clock_out_pin_oe = r.pin_oe;

endmodule // rco_ref_clock_out

// ### tb/rco_checker.sv
/* assertions on the reference clock output ports.
   assumes: bound to rco_ref_clock_out, one clock domain. */
`timescale 1ns/1ps
// ==========
// checker
module rco_checker (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        sleep_mode,
    input  wire logic        ref_clock_out_pin,
    input  wire logic        ref_clock_out_pin_oe
);
    logic [15:8] sh;
    logic [4:0]  age;
    logic        slp_q;
    logic        wr_ctrl;
    logic        st;
    // shadow of the control byte; age restarts on any change, so stop latency is never judged
    assign wr_ctrl = pready && psel && pwrite && paddr == 12'h000 && pstrb[1];
    assign st = age == 5'h1f;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh <= 8'h00;
            age <= 5'h00;
            slp_q <= 1'b0;
        end else begin
            sh <= wr_ctrl ? pwdata[15:8] : sh;
            // a frozen enable stalls the pin, so it restarts the settle count as well
            age <= (wr_ctrl || !clk_en || sleep_mode != slp_q) ? 5'h00 : age + {4'h0, age != 5'h1f};
            slp_q <= sleep_mode;
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && penable && !pready && clk_en |=> pready || !clk_en)
        else $error("no answer one cycle after access");
    a_unmapped_err: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
        else $error("error flag wrong for address");
    a_unused_zero: assert property (pready && !pwrite && paddr == 12'h000 |-> (prdata & 32'hffff_40ff) == 0)
        else $error("unimplemented control bits read nonzero");
    a_oe_follow: assert property (wr_ctrl |-> ##2 ref_clock_out_pin_oe == $past(pwdata[15], 2))
        else $error("pin enable does not follow control write");
    a_pin_off: assert property (st && !ref_clock_out_pin_oe |-> !ref_clock_out_pin)
        else $error("pin active while disabled");
    a_half_toggle: assert property ((st && sh[15] && sh[12:8] == 5'h01 && !sleep_mode) ##1 (!sleep_mode && age != 0)
        |-> ref_clock_out_pin != $past(ref_clock_out_pin))
        else $error("divide by two does not toggle each cycle");
    a_sleep_park: assert property (st && sleep_mode && !sh[13] |-> !ref_clock_out_pin)
        else $error("pin runs in sleep");
    a_code0_high: assert property (st && sh[15] && sh[12:8] == 5'h00 && !sleep_mode |-> ref_clock_out_pin)
        else $error("undivided system clock not passed");
    c_osc: cover property (sh[12] && st && $rose(ref_clock_out_pin));
    c_sleep_run: cover property (sleep_mode && sh[13] && $rose(ref_clock_out_pin));
    c_slverr: cover property (pready && pslverr);
endmodule // rco_checker

bind rco_ref_clock_out rco_checker rco_checker_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode), .ref_clock_out_pin(ref_clock_out_pin),
    .ref_clock_out_pin_oe(ref_clock_out_pin_oe));

// ### tb/rco_clocked_load.sv
/* load clocked by the reference output pin: high time and rising edges.
   assumes: board pull-down, so a released pin reads low. */
`timescale 1ns/1ps
// ==========
// load model
module rco_clocked_load (
    input  wire logic        pclk,
    input  wire logic        pin,
    input  wire logic        pin_oe,
    output logic      [19:0] hi_len,
    output logic      [19:0] rises
);
    logic        lvl;
    logic        lvl_q = 1'b0;
    logic [19:0] run   = 20'h0_0000;
    assign lvl = pin_oe & pin;
    initial begin
        hi_len = 20'h0_0000;
        rises = 20'h0_0000;
    end
    // counts high cycles; a fall reports the run length
    always @(posedge pclk) begin
        lvl_q <= lvl;
        run <= lvl ? run + 20'h0_0001 : 20'h0_0000;
        if (lvl_q && !lvl) hi_len <= run;
        if (lvl && !lvl_q) rises <= rises + 20'h0_0001;
    end
endmodule // rco_clocked_load

// ### tb/rco_ref_clock_out_bench.sv
/* self-checking bench for the reference clock output block.
   assumes: checker bound elsewhere; oscillator runs at pclk/8. */
`timescale 1ns/1ps
`define CHK(g,x) begin cmp_count++; if ((g) !== (x)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x); end end
// ==========
// bench
module rco_ref_clock_out_bench import rco_pkg::*; ;
    logic        pclk, pready, pslverr, pin, pin_oe, erv;
    logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        osc_clk_in = 1'b0, sleep_mode = 1'b0;
    logic [1:0]  oc = 2'h0;
    logic        ce = 1'b1;
    logic [3:0]  ps = 4'hf;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
    logic [19:0] hi_len, rises, r0;
    int          fails = 0, cmp_count = 0;
    rco_ref_clock_out rco_ref_clock_out_inst (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(ps), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_clk_in(osc_clk_in), .sleep_mode(sleep_mode),
        .ref_clock_out_pin(pin), .ref_clock_out_pin_oe(pin_oe));
    rco_clocked_load rco_clocked_load_inst (.pclk(pclk), .pin(pin), .pin_oe(pin_oe), .hi_len(hi_len), .rises(rises));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // oscillator free-running from time zero, so it is up before selection
    always @(posedge pclk) begin
        oc <= oc + 2'h1;
        if (oc == 2'h3) osc_clk_in <= ~osc_clk_in;
    end
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no cycle budget here: a slave that never answers is caught by the watchdog
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rdv, x)
        `CHK(erv, xe)
    endtask
    // skips the first, possibly cut, high phase after a change
    task automatic meas(input logic [19:0] x);
        r0 = rises;
        while (rises < r0 + 20'h0_0002) @(posedge pclk);
        while (pin) @(posedge pclk);
        repeat (2) @(posedge pclk);
        `CHK(hi_len, x)
    endtask
    initial begin
        #200_000;
        fails++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h000, 32'h0000_0000, 1'b0);
        wr(12'h000, 32'h0000_ffff);
        rd(12'h000, 32'h0000_bf00, 1'b0);
        `CHK(pin_oe, 1'b1)
        rd(12'h008, 32'h0000_0000, 1'b1);
        wr(12'h00c, 32'h0000_0000);
        `CHK(erv, 1'b1)
        wr(12'h004, 32'h0000_0000);
        `CHK(erv, 1'b0)
        // low lane only: the upper byte must keep its value
        ps <= 4'h1;
        wr(12'h000, 32'h0000_0000);
        ps <= 4'hf;
        rd(12'h000, 32'h0000_bf00, 1'b0);
        for (int n = 1; n <= 10; n++) begin
            wr(12'h000, 32'h0000_8000 | (n << 8));
            meas(20'h0_0001 << (n - 1));
        end
        wr(12'h000, 32'h0000_8000);
        repeat (40) @(posedge pclk);
        `CHK(pin, 1'b1)
        wr(12'h000, 32'h0000_9200);
        meas(20'h0_0010);
        rd(12'h004, 32'h0000_0005, 1'b0);
        wr(12'h000, 32'h0000_8100);
        sleep_mode <= 1'b1;
        repeat (40) @(posedge pclk);
        r0 = rises;
        repeat (20) @(posedge pclk);
        `CHK(rises, r0)
        rd(12'h004, 32'h0000_0000, 1'b0);
        wr(12'h000, 32'h0000_a100);
        meas(20'h0_0001);
        sleep_mode <= 1'b0;
        // let divide-by-two settle so the toggle assertion gets its turn
        repeat (40) @(posedge pclk);
        // enable low freezes the pin, so no new rising edge may appear
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        r0 = rises;
        repeat (10) @(posedge pclk);
        `CHK(rises, r0)
        ce <= 1'b1;
        // reset in mid-run clears the control word and drops the pin
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK({pin_oe, pin}, 2'h0)
        rd(12'h000, 32'h0000_0000, 1'b0);
        wr(12'h000, 32'h0000_0000);
        repeat (40) @(posedge pclk);
        `CHK({pin_oe, pin}, 2'h0)
        close_out();
    end
endmodule // rco_ref_clock_out_bench
